// ---- design/xsb_pkg.sv ----
package xsb_pkg;
    // ------------------------------------------------------------
    // word layout: transfer t at [36t+35:36t], lane n data [8n+7:8n], ctrl [32+n]
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int LANES  = 4;
    localparam int XFER_W = 36;
    localparam int WORD_W = 72;

    // ------------------------------------------------------------
    // control octets and code groups
    // ------------------------------------------------------------
    localparam logic [7:0] OCT_IDLE  = 8'h07;
    localparam logic [7:0] OCT_SEQ   = 8'h9C;
    localparam logic [7:0] OCT_START = 8'hFB;
    localparam logic [7:0] OCT_TERM  = 8'hFD;
    localparam logic [7:0] OCT_ERR   = 8'hFE;
    localparam logic [7:0] K_ALIGN   = 8'h7C;
    localparam logic [7:0] K_SYNC    = 8'hBC;
    localparam logic [7:0] K_SKIP    = 8'h1C;

    localparam logic [XFER_W-1:0] IDLE_XFER = {4'hF, {4{OCT_IDLE}}};
    localparam logic [WORD_W-1:0] IDLE_WORD = {IDLE_XFER, IDLE_XFER};

    // ------------------------------------------------------------
    // slip buffer and idle generator
    // ------------------------------------------------------------
    localparam int         SLIP_DEPTH = 256;
    localparam int         SLIP_PE    = 64;
    localparam int         SLIP_PF    = 192;
    localparam logic [4:0] A_MIN_GAP  = 5'h10;
    localparam logic [6:0] PRBS_SEED  = 7'h7F;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 25_000_000;
    localparam int RXCLK_HZ    = 3_125_000;
    localparam int RX_HALF_CYC = CLK_HZ / (2 * RXCLK_HZ);
    localparam int RX_MID_CYC  = RX_HALF_CYC / 2;

    // packet state after a word: start opens, terminate closes, in transfer order
    function automatic logic pkt_next(input logic cur, input logic [WORD_W-1:0] w);
        logic r;
        r = cur;
        for (int t = 0; t < 2; t++) begin
            if (w[XFER_W*t+DATA_W] && (w[XFER_W*t +: 8] == OCT_START)) begin
                r = 1'b1;
            end
            for (int n = 0; n < LANES; n++) begin
                if (w[XFER_W*t+DATA_W+n] && (w[XFER_W*t+8*n +: 8] == OCT_TERM)) begin
                    r = 1'b0;
                end
            end
        end
        return r;
    endfunction
endpackage

// ---- design/xsb_bridge.sv ----
`timescale 1ns/1ps

module xsb_slip
    import xsb_pkg::*;
#(
    parameter int DEPTH = SLIP_DEPTH,
    parameter int PE    = SLIP_PE,
    parameter int PF    = SLIP_PF
) (
    // clock, reset and enable
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              en_i,
    // write side
    input  wire logic              wr_valid_i,
    input  wire logic [WORD_W-1:0] wr_data_i,
    // read side
    input  wire logic              rd_req_i,
    output logic                   rd_valid_o,
    output logic      [WORD_W-1:0] rd_data_o,
    // occupancy {pempty, pfull, empty, full}
    output logic      [3:0]        flags_o
);
    localparam int             AW    = $clog2(DEPTH);
    localparam logic [AW:0]    LV_PE = (AW+1)'(PE);
    localparam logic [AW:0]    LV_PF = (AW+1)'(PF);
    localparam logic [AW:0]    LV_FU = (AW+1)'(DEPTH);

    logic [WORD_W-1:0] mem_ff [DEPTH];
    logic [WORD_W-1:0] nxt_mem [DEPTH];
    logic [AW:0]       wptr_ff, nxt_wptr, rptr_ff, nxt_rptr, level;
    logic              wr_pkt_ff, nxt_wr_pkt, rd_pkt_ff, nxt_rd_pkt;
    logic              started_ff, nxt_started, filling_ff, nxt_filling;
    logic              rd_valid_ff, nxt_rd_valid, del, full, empty;
    logic [WORD_W-1:0] rd_data_ff, nxt_rd_data;
    logic [3:0]        flags_ff, nxt_flags;

    always_comb begin
        level        = wptr_ff - rptr_ff;
        full         = (level == LV_FU);
        empty        = (level == '0);
        nxt_mem      = mem_ff;
        nxt_wptr     = wptr_ff;
        nxt_rptr     = rptr_ff;
        nxt_wr_pkt   = wr_pkt_ff;
        nxt_rd_pkt   = rd_pkt_ff;
        nxt_started  = started_ff;
        nxt_filling  = filling_ff;
        nxt_rd_valid = 1'b0;
        nxt_rd_data  = rd_data_ff;
        nxt_flags    = {level < LV_PE, level >= LV_PF, empty, full};
        // a buffer at or above the pfull level drops whole idle words, but only between packets
        del = wr_valid_i && !wr_pkt_ff && (wr_data_i == IDLE_WORD) && (level >= LV_PF);
        if (wr_valid_i) begin
            nxt_wr_pkt = pkt_next(wr_pkt_ff, wr_data_i);
            if (!full && !del) begin
                nxt_mem[wptr_ff[AW-1:0]] = wr_data_i;
                nxt_wptr                 = wptr_ff + 1'b1;
            end
        end
        if (level >= LV_PE) begin
            nxt_started = 1'b1;
        end
        if (started_ff && !rd_pkt_ff && (level < LV_PE)) begin
            nxt_filling = 1'b1;
        end
        if (level >= LV_PF) begin
            nxt_filling = 1'b0;
        end
        if (rd_req_i) begin
            // a dry buffer inside a packet answers nothing, so idles only fall between packets
            if (started_ff && !empty && (rd_pkt_ff || !filling_ff)) begin
                nxt_rd_valid = 1'b1;
                nxt_rd_data  = mem_ff[rptr_ff[AW-1:0]];
                nxt_rd_pkt   = pkt_next(rd_pkt_ff, mem_ff[rptr_ff[AW-1:0]]);
                nxt_rptr     = rptr_ff + 1'b1;
            end else if (!rd_pkt_ff) begin
                nxt_rd_valid = 1'b1;
                nxt_rd_data  = IDLE_WORD;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_ff     <= '0;
            rptr_ff     <= '0;
            wr_pkt_ff   <= 1'b0;
            rd_pkt_ff   <= 1'b0;
            started_ff  <= 1'b0;
            filling_ff  <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= IDLE_WORD;
            flags_ff    <= 4'h2;
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= IDLE_WORD;
            end
        end else if (en_i) begin
            wptr_ff     <= nxt_wptr;
            rptr_ff     <= nxt_rptr;
            wr_pkt_ff   <= nxt_wr_pkt;
            rd_pkt_ff   <= nxt_rd_pkt;
            started_ff  <= nxt_started;
            filling_ff  <= nxt_filling;
            rd_valid_ff <= nxt_rd_valid;
            rd_data_ff  <= nxt_rd_data;
            flags_ff    <= nxt_flags;
            mem_ff      <= nxt_mem;
        end
    end

    assign rd_valid_o = rd_valid_ff;
    assign rd_data_o  = rd_data_ff;
    assign flags_o    = flags_ff;
endmodule // xsb_slip

module xsb_bridge
    import xsb_pkg::*;
#(
    parameter int HALF_CYC = RX_HALF_CYC
) (
    // clock, enable and reset
    input  wire logic                clk_i,
    input  wire logic                en_i,
    input  wire logic                rst_n_i,
    // media interface, transmit direction (inputs)
    input  wire logic                xgmii_txc_i,
    input  wire logic [DATA_W-1:0]   xgmii_txd_i,
    input  wire logic [LANES-1:0]    xgmii_txctl_i,
    // media interface, receive direction (outputs)
    output logic                     xgmii_rxc_o,
    output logic      [DATA_W-1:0]   xgmii_rxd_o,
    output logic      [LANES-1:0]    xgmii_rxctl_o,
    // serdes receive words
    input  wire logic                ser_rx_valid_i,
    input  wire logic [2*WORD_W-1:0] ser_rx_data_i,
    // serdes transmit words
    output logic                     ser_tx_valid_o,
    output logic      [WORD_W-1:0]   ser_tx_data_o,
    input  wire logic                ser_tx_ready_i,
    // slip buffer flags {pempty, pfull, empty, full}
    output logic      [3:0]          tx_flags_o,
    output logic      [3:0]          rx_flags_o
);
    localparam int CW = $clog2(HALF_CYC) + 1;

    // symbol decode: A, K and R become idle, all else passes as is
    function automatic logic [WORD_W-1:0] dec_word(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] r;
        logic [7:0]        s;
        r = w;
        for (int t = 0; t < 2; t++) begin
            for (int n = 0; n < LANES; n++) begin
                s = w[XFER_W*t+8*n +: 8];
                if (w[XFER_W*t+DATA_W+n] && ((s == K_ALIGN) || (s == K_SYNC) || (s == K_SKIP))) begin
                    r[XFER_W*t+8*n +: 8] = OCT_IDLE;
                end
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // reset release and link input synchronisers
    // ------------------------------------------------------------
    logic              rst_s1_ff, rst_s2_ff, rst_n;
    logic              txc_s1_ff, txc_s2_ff, txc_prev_ff;
    logic [XFER_W-1:0] txd_s1_ff, txd_s2_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else if (en_i) begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            txc_s1_ff   <= 1'b0;
            txc_s2_ff   <= 1'b0;
            txc_prev_ff <= 1'b0;
            txd_s1_ff   <= IDLE_XFER;
            txd_s2_ff   <= IDLE_XFER;
        end else if (en_i) begin
            txc_s1_ff   <= xgmii_txc_i;
            txc_s2_ff   <= txc_s1_ff;
            txc_prev_ff <= txc_s2_ff;
            txd_s1_ff   <= {xgmii_txctl_i, xgmii_txd_i};
            txd_s2_ff   <= txd_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // transmit: double edge capture into 72-bit words
    // ------------------------------------------------------------
    logic [XFER_W-1:0] tx_lo_ff, nxt_tx_lo;
    logic              tx_wv_ff, nxt_tx_wv;
    logic [WORD_W-1:0] tx_wd_ff, nxt_tx_wd;

    always_comb begin
        nxt_tx_lo = tx_lo_ff;
        nxt_tx_wv = 1'b0;
        nxt_tx_wd = tx_wd_ff;
        if (txc_s2_ff && !txc_prev_ff) begin
            nxt_tx_lo = txd_s2_ff;
        end
        if (!txc_s2_ff && txc_prev_ff) begin
            nxt_tx_wv = 1'b1;
            nxt_tx_wd = {txd_s2_ff, tx_lo_ff};
        end
    end

    // ------------------------------------------------------------
    // receive: 144-bit words split in two and decoded
    // ------------------------------------------------------------
    logic [WORD_W-1:0] rx_pend_ff, nxt_rx_pend, rx_wd_ff, nxt_rx_wd;
    logic              rx_pend_v_ff, nxt_rx_pend_v, rx_wv_ff, nxt_rx_wv;

    always_comb begin
        nxt_rx_pend   = rx_pend_ff;
        nxt_rx_pend_v = 1'b0;
        nxt_rx_wv     = 1'b0;
        nxt_rx_wd     = rx_wd_ff;
        // a new word one cycle after another would overwrite the pending half
        if (ser_rx_valid_i) begin
            nxt_rx_wv     = 1'b1;
            nxt_rx_wd     = dec_word(ser_rx_data_i[WORD_W-1:0]);
            nxt_rx_pend   = dec_word(ser_rx_data_i[2*WORD_W-1:WORD_W]);
            nxt_rx_pend_v = 1'b1;
        end else if (rx_pend_v_ff) begin
            nxt_rx_wv = 1'b1;
            nxt_rx_wd = rx_pend_ff;
        end
    end

    // ------------------------------------------------------------
    // slip buffers
    // ------------------------------------------------------------
    logic              tx_req_ff, nxt_tx_req, tx_rv, rx_req_ff, nxt_rx_req, rx_rv;
    logic [WORD_W-1:0] tx_rd, rx_rd;

    xsb_slip u_tx_slip (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .en_i       (en_i),
        .wr_valid_i (tx_wv_ff),
        .wr_data_i  (tx_wd_ff),
        .rd_req_i   (tx_req_ff),
        .rd_valid_o (tx_rv),
        .rd_data_o  (tx_rd),
        .flags_o    (tx_flags_o)
    );

    xsb_slip u_rx_slip (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .en_i       (en_i),
        .wr_valid_i (rx_wv_ff),
        .wr_data_i  (rx_wd_ff),
        .rd_req_i   (rx_req_ff),
        .rd_valid_o (rx_rv),
        .rd_data_o  (rx_rd),
        .flags_o    (rx_flags_o)
    );

    // ------------------------------------------------------------
    // transmit encoder with idle randomiser and two-entry buffer
    // ------------------------------------------------------------
    logic [4:0]        a_cnt_ff, nxt_a_cnt;
    logic [6:0]        prbs_ff, nxt_prbs;
    logic [WORD_W-1:0] buf_ff [2];
    logic [WORD_W-1:0] nxt_buf [2];
    logic [1:0]        cnt_ff, nxt_cnt;
    logic              txv_ff, nxt_txv, pop;
    logic [WORD_W-1:0] enc;
    logic [2:0]        occ;

    always_comb begin
        nxt_a_cnt = a_cnt_ff;
        nxt_prbs  = prbs_ff;
        enc       = tx_rd;
        for (int t = 0; t < 2; t++) begin
            nxt_prbs = {nxt_prbs[5:0], nxt_prbs[6] ^ nxt_prbs[5]};
            if (tx_rd[XFER_W*t +: XFER_W] == IDLE_XFER) begin
                if (nxt_a_cnt == 5'h00) begin
                    enc[XFER_W*t +: DATA_W] = {LANES{K_ALIGN}};
                    nxt_a_cnt               = A_MIN_GAP + {1'b0, nxt_prbs[3:0]};
                end else begin
                    enc[XFER_W*t +: DATA_W] = nxt_prbs[0] ? {LANES{K_SKIP}} : {LANES{K_SYNC}};
                    nxt_a_cnt               = nxt_a_cnt - 5'h01;
                end
            end else begin
                for (int n = 0; n < LANES; n++) begin
                    if (tx_rd[XFER_W*t+DATA_W+n] && (tx_rd[XFER_W*t+8*n +: 8] == OCT_IDLE)) begin
                        enc[XFER_W*t+8*n +: 8] = K_SYNC;
                    end
                end
                if (nxt_a_cnt != 5'h00) begin
                    nxt_a_cnt = nxt_a_cnt - 5'h01;
                end
            end
        end
        if (!tx_rv) begin
            nxt_a_cnt = a_cnt_ff;
            nxt_prbs  = prbs_ff;
        end
        // requests in flight count against the buffer so a stall never overflows it
        occ        = {1'b0, cnt_ff} + {2'b00, tx_req_ff} + {2'b00, tx_rv};
        nxt_tx_req = (occ < 3'h2);
        pop        = (cnt_ff != 2'h0) && ser_tx_ready_i;
        nxt_buf    = buf_ff;
        nxt_cnt    = cnt_ff;
        if (pop) begin
            nxt_buf[0] = buf_ff[1];
            nxt_cnt    = cnt_ff - 2'h1;
        end
        if (tx_rv) begin
            nxt_buf[nxt_cnt[0]] = enc;
            nxt_cnt             = nxt_cnt + 2'h1;
        end
        nxt_txv = (nxt_cnt != 2'h0);
    end

    // ------------------------------------------------------------
    // receive output: forwarded clock and double edge data
    // ------------------------------------------------------------
    logic [CW-1:0]       hc_ff, nxt_hc;
    logic                rxc_ff, nxt_rxc;
    logic [WORD_W-1:0]   cur_ff, nxt_cur;
    logic [XFER_W-1:0]   rxo_ff, nxt_rxo;

    always_comb begin
        nxt_hc     = hc_ff + 1'b1;
        nxt_rxc    = rxc_ff;
        nxt_cur    = cur_ff;
        nxt_rxo    = rxo_ff;
        nxt_rx_req = 1'b0;
        if (hc_ff == CW'(HALF_CYC - 1)) begin
            nxt_hc  = '0;
            nxt_rxc = !rxc_ff;
        end
        // data moves one cycle past mid-phase, never on a forwarded edge, so it is stable around each edge
        if (hc_ff == CW'(HALF_CYC / 2)) begin
            if (!rxc_ff) begin
                nxt_rxo = cur_ff[XFER_W-1:0];
            end else begin
                nxt_rxo    = cur_ff[WORD_W-1:XFER_W];
                nxt_rx_req = 1'b1;
            end
        end
        // the fetch answer lands at the start of the low phase; none means the buffer ran dry
        if ((hc_ff == '0) && !rxc_ff) begin
            nxt_cur = rx_rv ? rx_rd : IDLE_WORD;
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_lo_ff     <= IDLE_XFER;
            tx_wv_ff     <= 1'b0;
            tx_wd_ff     <= IDLE_WORD;
            rx_pend_ff   <= IDLE_WORD;
            rx_pend_v_ff <= 1'b0;
            rx_wv_ff     <= 1'b0;
            rx_wd_ff     <= IDLE_WORD;
            tx_req_ff    <= 1'b0;
            rx_req_ff    <= 1'b0;
            a_cnt_ff     <= '0;
            prbs_ff      <= PRBS_SEED;
            buf_ff[0]    <= IDLE_WORD;
            buf_ff[1]    <= IDLE_WORD;
            cnt_ff       <= '0;
            txv_ff       <= 1'b0;
            hc_ff        <= '0;
            rxc_ff       <= 1'b0;
            cur_ff       <= IDLE_WORD;
            rxo_ff       <= IDLE_XFER;
        end else if (en_i) begin
            tx_lo_ff     <= nxt_tx_lo;
            tx_wv_ff     <= nxt_tx_wv;
            tx_wd_ff     <= nxt_tx_wd;
            rx_pend_ff   <= nxt_rx_pend;
            rx_pend_v_ff <= nxt_rx_pend_v;
            rx_wv_ff     <= nxt_rx_wv;
            rx_wd_ff     <= nxt_rx_wd;
            tx_req_ff    <= nxt_tx_req;
            rx_req_ff    <= nxt_rx_req;
            a_cnt_ff     <= nxt_a_cnt;
            prbs_ff      <= nxt_prbs;
            buf_ff       <= nxt_buf;
            cnt_ff       <= nxt_cnt;
            txv_ff       <= nxt_txv;
            hc_ff        <= nxt_hc;
            rxc_ff       <= nxt_rxc;
            cur_ff       <= nxt_cur;
            rxo_ff       <= nxt_rxo;
        end
    end

    assign xgmii_rxc_o    = rxc_ff;
    assign xgmii_rxd_o    = rxo_ff[DATA_W-1:0];
    assign xgmii_rxctl_o  = rxo_ff[XFER_W-1:DATA_W];
    assign ser_tx_valid_o = txv_ff;
    assign ser_tx_data_o  = buf_ff[0];
endmodule // xsb_bridge

// ---- verification/xsb_bridge_sva.sv ----
`timescale 1ns/1ps
module xsb_bridge_chk
    import xsb_pkg::*;
(
    // clock and reset
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    // watched outputs and the serdes ready input
    input wire logic              xgmii_rxc_o,
    input wire logic [DATA_W-1:0] xgmii_rxd_o,
    input wire logic [LANES-1:0]  xgmii_rxctl_o,
    input wire logic              ser_tx_valid_o,
    input wire logic [WORD_W-1:0] ser_tx_data_o,
    input wire logic              ser_tx_ready_i,
    input wire logic [3:0]        tx_flags_o,
    input wire logic [3:0]        rx_flags_o
);
    logic k_leak;
    logic i_leak;
    // a code group or a raw idle octet must never leak through its coder
    always_comb begin
        k_leak = 1'b0;
        i_leak = 1'b0;
        for (int n = 0; n < LANES; n++) begin
            if (xgmii_rxctl_o[n] && (xgmii_rxd_o[8*n +: 8] inside {K_ALIGN, K_SYNC, K_SKIP})) begin
                k_leak = 1'b1;
            end
            for (int t = 0; t < 2; t++) begin
                if (ser_tx_data_o[XFER_W*t+DATA_W+n] && (ser_tx_data_o[XFER_W*t+8*n +: 8] == OCT_IDLE)) begin
                    i_leak = 1'b1;
                end
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_reset_idle;
        $rose(rst_n_i) |-> xgmii_rxd_o == {4{OCT_IDLE}} && xgmii_rxctl_o == 4'hF && !ser_tx_valid_o
            && tx_flags_o == 4'h2 && rx_flags_o == 4'h2;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
    property p_rxc_half;
        $changed(xgmii_rxc_o) |=> $stable(xgmii_rxc_o) [*3] ##1 $changed(xgmii_rxc_o);
    endproperty
    a_rxc_half: assert property (p_rxc_half) else $error("receive clock half period wrong");
    property p_rxd_half;
        $changed(xgmii_rxd_o) |=> $stable(xgmii_rxd_o) [*3];
    endproperty
    a_rxd_half: assert property (p_rxd_half) else $error("receive data held too briefly");
    property p_rxd_off_edge;
        $changed(xgmii_rxd_o) |-> $stable(xgmii_rxc_o);
    endproperty
    a_rxd_off_edge: assert property (p_rxd_off_edge) else $error("receive data moved with its clock");
    property p_tx_hold;
        ser_tx_valid_o && !ser_tx_ready_i |=> ser_tx_valid_o && $stable(ser_tx_data_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("serdes word dropped while stalled");
    property p_tx_no_idle;
        ser_tx_valid_o |-> !i_leak;
    endproperty
    a_tx_no_idle: assert property (p_tx_no_idle) else $error("raw idle octet sent to serdes");
    property p_rx_decode;
        !k_leak;
    endproperty
    a_rx_decode: assert property (p_rx_decode) else $error("code group left undecoded");
    property p_flags;
        (!tx_flags_o[0] || tx_flags_o[2]) && (!rx_flags_o[0] || rx_flags_o[2])
            && !(tx_flags_o[3] && tx_flags_o[2]) && !(rx_flags_o[3] && rx_flags_o[2]);
    endproperty
    a_flags: assert property (p_flags) else $error("occupancy flags contradict");
    c_rx_data: cover property (xgmii_rxctl_o == 4'h0);
    c_tx_stall: cover property (ser_tx_valid_o && !ser_tx_ready_i);
    c_rx_start: cover property ($fell(rx_flags_o[3]));
endmodule // xsb_bridge_chk
bind xsb_bridge xsb_bridge_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .xgmii_rxc_o(xgmii_rxc_o),
    .xgmii_rxd_o(xgmii_rxd_o), .xgmii_rxctl_o(xgmii_rxctl_o), .ser_tx_valid_o(ser_tx_valid_o),
    .ser_tx_data_o(ser_tx_data_o), .ser_tx_ready_i(ser_tx_ready_i), .tx_flags_o(tx_flags_o), .rx_flags_o(rx_flags_o));

// ---- verification/xsb_mac_model.sv ----
`timescale 1ns/1ps
module xsb_mac_model
    import xsb_pkg::*;
(
    // media interface, transmit direction
    output logic              txc_o,
    output logic [DATA_W-1:0] txd_o,
    output logic [LANES-1:0]  txctl_o
);
    initial begin
        txc_o = 1'b0;
        txd_o = {4{OCT_IDLE}};
        txctl_o = 4'hF;
    end
    // the link clock runs only inside a word; lines change mid half-period
    task automatic send(input logic [WORD_W-1:0] w);
        {txctl_o, txd_o} <= w[XFER_W-1:0];
        #80 txc_o <= 1'b1;
        #80 {txctl_o, txd_o} <= w[WORD_W-1:XFER_W];
        #80 txc_o <= 1'b0;
        #80;
    endtask
endmodule // xsb_mac_model

// ---- verification/test_xsb_bridge.sv ----
`timescale 1ns/1ps
module test_xsb_bridge;
    import xsb_pkg::*;
    logic                clk_i;
    logic                rst_n_i;
    logic                en_i;
    logic                txc;
    logic [DATA_W-1:0]   txd;
    logic [LANES-1:0]    txctl;
    logic                rxc;
    logic [DATA_W-1:0]   rxd;
    logic [LANES-1:0]    rxctl;
    logic                ser_rx_valid;
    logic [2*WORD_W-1:0] ser_rx_data;
    logic                ser_tx_valid;
    logic [WORD_W-1:0]   ser_tx_data;
    logic                ser_tx_ready = 1'b0;
    logic [3:0]          tx_flags;
    logic [3:0]          rx_flags;
    logic                rxc_q = 1'b0;
    logic [XFER_W-1:0]   rx_q[$];
    logic [XFER_W-1:0]   tx_q[$];
    int                  num_errors = 0;
    int                  cmp_count = 0;
    int                  cyc = 0;
    xsb_mac_model u_mac (.txc_o(txc), .txd_o(txd), .txctl_o(txctl));
    xsb_bridge #(.HALF_CYC(4)) u_dut (.clk_i(clk_i), .en_i(en_i), .rst_n_i(rst_n_i), .xgmii_txc_i(txc),
        .xgmii_txd_i(txd), .xgmii_txctl_i(txctl), .xgmii_rxc_o(rxc), .xgmii_rxd_o(rxd), .xgmii_rxctl_o(rxctl),
        .ser_rx_valid_i(ser_rx_valid), .ser_rx_data_i(ser_rx_data), .ser_tx_valid_o(ser_tx_valid),
        .ser_tx_data_o(ser_tx_data), .ser_tx_ready_i(ser_tx_ready), .tx_flags_o(tx_flags), .rx_flags_o(rx_flags));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // --------------------------------------------------------
    // collectors, stalling receiver, hang limit
    // --------------------------------------------------------
    always @(negedge clk_i) begin
        rxc_q <= rxc;
        if (rxc !== rxc_q) begin
            rx_q.push_back({rxctl, rxd});
        end
        if (ser_tx_valid && ser_tx_ready) begin
            tx_q.push_back(ser_tx_data[XFER_W-1:0]);
            tx_q.push_back(ser_tx_data[WORD_W-1:XFER_W]);
        end
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        ser_tx_ready <= (cyc % 5 != 0) && (cyc % 200 > 30);
        if (cyc == 6000) begin
            num_errors++;
            end_sim();
        end
    end
    // transfer j of the test packet; m: 0 media side, 1 serdes receive, 2 serdes transmit
    function automatic logic [XFER_W-1:0] pkt_x(input int j, input int m);
        logic [23:0] k3 = (m == 0) ? {3{OCT_IDLE}} : (m == 1) ? {K_SKIP, K_SYNC, K_ALIGN} : {3{K_SYNC}};
        if (j == 0) return {4'h1, 24'hC0FFEE, OCT_START};
        if (j == 100) return {4'h2, 16'h1234, OCT_ERR, 8'h55};
        if (j == 158) return {4'hF, k3, OCT_TERM};
        if (j == 159) return {4'hF, k3, OCT_SEQ};
        return {4'h0, 32'h5A5A0000 + 32'(j)};
    endfunction
    function automatic bit is_idle(input logic [XFER_W-1:0] x);
        is_idle = (x[35:32] === 4'hF);
        for (int n = 0; n < LANES; n++) begin
            if (!(x[8*n +: 8] inside {OCT_IDLE, K_ALIGN, K_SYNC, K_SKIP})) is_idle = 1'b0;
        end
    endfunction
    task automatic chk(input string what, input logic [XFER_W-1:0] exp, input logic [XFER_W-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // idle columns are skipped between packets, where insertion and deletion may add or drop them
    task automatic cmp_stream(input string what, ref logic [XFER_W-1:0] q[$], input int m);
        int j = 0;
        int gaps = 0;
        foreach (q[i]) begin
            if (!is_idle(q[i])) begin
                chk(what, pkt_x(j, m), q[i]);
                j++;
            end else if (j > 0 && j < 160) begin
                gaps++;
            end
        end
        chk(what, 36'(160), 36'(j));
        chk({what, " gap"}, 36'(0), 36'(gaps));
    endtask
    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_reset();
        repeat (20) @(negedge clk_i);
        chk("rx idle", IDLE_XFER, {rxctl, rxd});
        chk("flags", 36'hAA, 36'({tx_flags, rx_flags}));
    endtask
    task automatic t_rx();
        for (int p = 0; p < 40; p++) begin
            if (p == 31) begin
                @(negedge clk_i);
                chk("rx hold", IDLE_XFER, {rxctl, rxd});
            end
            @(posedge clk_i);
            ser_rx_valid <= 1'b1;
            ser_rx_data <= {pkt_x(4*p+3, 1), pkt_x(4*p+2, 1), pkt_x(4*p+1, 1), pkt_x(4*p, 1)};
            @(posedge clk_i);
            ser_rx_valid <= 1'b0;
            ser_rx_data <= ~ser_rx_data;
        end
        repeat (900) @(posedge clk_i);
        cmp_stream("rx stream", rx_q, 0);
    endtask
    task automatic t_tx();
        for (int w = 0; w < 80; w++) begin
            u_mac.send({pkt_x(2*w+1, 0), pkt_x(2*w, 0)});
        end
        repeat (500) @(posedge clk_i);
        cmp_stream("tx stream", tx_q, 2);
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        rst_n_i = 1'b0;
        en_i = 1'b1;
        ser_rx_valid = 1'b0;
        ser_rx_data = '0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_rx();
        t_tx();
        end_sim();
    end
endmodule // test_xsb_bridge
